// [tapid_pkg.sv]
// Purpose: shared constants and types of the test port instruction decoder
// Assumes: one core clock domain; the test clock is sampled as a plain input
// Notes: boundary chain layout is a small stand-in for the real scan order
package tapid_pkg;

	// instruction register
	localparam int IR_W = 3;
	localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
	localparam logic [2:0] IR_CAPTURE_TOP = 3'h0;
	localparam logic [2:0] INS_EXTEST = 3'h0;
	localparam logic [2:0] INS_IDCODE = 3'h1;
	localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
	localparam logic [2:0] INS_PRIV_A = 3'h3;
	localparam logic [2:0] INS_SAMPLE = 3'h4;
	localparam logic [2:0] INS_PRIV_B = 3'h5;
	localparam logic [2:0] INS_PRIV_C = 3'h6;
	localparam logic [2:0] INS_BYPASS = 3'h7;
	localparam logic [2:0] IR_RESET_VAL = INS_IDCODE;

	// identification register; the value is arbitrary
	localparam int ID_W = 32;
	localparam logic [31:0] ID_ROM_VAL = 32'h0000_0001;

	// boundary chain: input cells, output cells, then fixed place holders
	localparam int BSR_IN_W = 4;
	localparam int BSR_OUT_W = 4;
	localparam int BSR_FILL_W = 2;
	localparam int BSR_W = BSR_IN_W + BSR_OUT_W + BSR_FILL_W;
	localparam int BSR_OUT_LSB = BSR_IN_W;
	localparam int BSR_FILL_LSB = BSR_IN_W + BSR_OUT_W;
	localparam logic [1:0] BSR_FILL_VAL = 2'h3;
	localparam logic [3:0] BSR_HOLD_RESET = 4'h0;

	// reset walk length of the test mode select line
	localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

	// synchroniser depth for pin levels
	localparam int SYNC_STAGES = 2;

	// test access states, one-hot
	typedef enum logic [15:0] {
		ST_RESET    = 16'h0001,
		ST_IDLE     = 16'h0002,
		ST_SEL_DR   = 16'h0004,
		ST_CAP_DR   = 16'h0008,
		ST_SHIFT_DR = 16'h0010,
		ST_EXIT1_DR = 16'h0020,
		ST_PAUSE_DR = 16'h0040,
		ST_EXIT2_DR = 16'h0080,
		ST_UPD_DR   = 16'h0100,
		ST_SEL_IR   = 16'h0200,
		ST_CAP_IR   = 16'h0400,
		ST_SHIFT_IR = 16'h0800,
		ST_EXIT1_IR = 16'h1000,
		ST_PAUSE_IR = 16'h2000,
		ST_EXIT2_IR = 16'h4000,
		ST_UPD_IR   = 16'h8000
	} tapid_state_e;

	// serial link pins as seen by the device
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} tapid_link_s;

	// boundary control toward the memory output drivers
	typedef struct packed {
		logic drive;
		logic hiz;
		logic [BSR_OUT_W-1:0] value;
	} tapid_bout_s;

endpackage

// [tapid_sync.sv]
// Purpose: two-stage synchroniser for levels arriving from other domains
// Assumes: every bit is an independent level
// Notes: only the second stage may be read by other logic
`timescale 1ns/100ps
`default_nettype none
module tapid_sync
	import tapid_pkg::*;
#(
	parameter int W = 1
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule // tapid_sync
`default_nettype wire

// [tapid_top.sv]
// Purpose: test access port instruction handling and data register paths
// Assumes: test clock far slower than core_clk; pin levels synchronised
// Notes: private codes route through bypass; output cells drive on fall
//
// Contract
// - capture-ir loads 01 into the two lowest instruction bits
// - shift-ir places instruction shifter between data in and out
// - new instruction acts only from update-ir onward
// - code 111 selects the one-bit bypass path in shift-dr
// - code 100 capture-dr copies pin levels into boundary chain
// - unbound boundary cells capture their fixed default value
// - boundary instructions shift the boundary chain in shift-dr
// - update-dr copies output cells into their holding latches
// - code 000 decodes as extest on the boundary chain
// - extest never isolates memory inputs other than main clock
// - extest drives held values onto outputs at falling test clock
// - extest capture-dr samples all pins and defaults in parallel
// - extest update-dr makes each output drive its held value
// - code 001 loads id rom at capture and shifts it out
// - instruction resets to idcode at power-up and test-logic-reset
// - code 010 acts as sample and forces memory outputs high-z
// - codes 011, 101, 110 are private; controller must not issue them
// - no internal test instruction; preload portion remains supported
// - instruction register is three bits wide
// - five rising edges with select high reach test-logic-reset
// - sample inputs on rising edge, change data out on falling
// - id register is 32 bits, least significant bit out first
`timescale 1ns/100ps
`default_nettype none
module tapid_top
	import tapid_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// serial test link
	input wire tapid_link_s link_in,
	output logic tdo_o,
	output logic tdo_oe,
	// pin levels of the memory ring
	input wire logic [BSR_IN_W-1:0] ring_in_lvl,
	input wire logic [BSR_OUT_W-1:0] ring_out_lvl,
	// boundary control of the memory outputs
	output tapid_bout_s bout
);

	localparam int SW = 3 + BSR_IN_W + BSR_OUT_W;
	logic [SW-1:0] sync_vec;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic [BSR_IN_W-1:0] in_s;
	logic [BSR_OUT_W-1:0] out_s;
	logic tck_d_reg;
	logic tck_rise;
	logic tck_fall;
	tapid_state_e state_reg;
	tapid_state_e state_next;
	logic [IR_W-1:0] ir_shift_reg;
	logic [IR_W-1:0] ir_reg;
	logic bypass_reg;
	logic [ID_W-1:0] id_shift_reg;
	logic [BSR_W-1:0] bsr_shift_reg;
	logic [BSR_OUT_W-1:0] hold_reg;
	logic [2:0] tms_run_reg;

	// boundary chain is the scan path for these codes
	function automatic logic is_boundary(input logic [IR_W-1:0] code);
		is_boundary = (code == INS_EXTEST) || (code == INS_SAMPLE)
			|| (code == INS_SAMPLE_Z);
	endfunction

	// selected register bit; private codes bypass
	function automatic logic dr_lsb(input logic [IR_W-1:0] code,
		input logic byp, input logic idb, input logic bsb);
		dr_lsb = is_boundary(code) ? bsb
			: (code == INS_IDCODE) ? idb : byp;
	endfunction

	// all outside levels pass two flops before use
	tapid_sync #(.W(SW)) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in({link_in.tck, link_in.tms, link_in.tdi,
			ring_in_lvl, ring_out_lvl}),
		.sync_out(sync_vec)
	);

	assign tck_s = sync_vec[SW-1];
	assign tms_s = sync_vec[SW-2];
	assign tdi_s = sync_vec[SW-3];
	assign in_s = sync_vec[BSR_OUT_W +: BSR_IN_W];
	assign out_s = sync_vec[BSR_OUT_W-1:0];

	// test clock edge finder
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			tck_d_reg <= 1'b0;
		else
			tck_d_reg <= tck_s;
	end

	assign tck_rise = tck_s && !tck_d_reg;
	assign tck_fall = !tck_s && tck_d_reg;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET:    state_next = tms_s ? ST_RESET : ST_IDLE;
			ST_IDLE:     state_next = tms_s ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR:   state_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR:   state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: state_next = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: state_next = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: state_next = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR:   state_next = tms_s ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR:   state_next = tms_s ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR:   state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: state_next = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: state_next = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: state_next = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR:   state_next = tms_s ? ST_SEL_DR : ST_IDLE;
			default:     state_next = ST_RESET;
		endcase
	end

	// state advances on each rising test clock edge
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state_reg <= ST_RESET;
		else if (tck_rise)
			state_reg <= state_next;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			tms_run_reg <= 3'h0;
		else if (tck_rise)
			tms_run_reg <= !tms_s ? 3'h0 :
				(tms_run_reg == TMS_RESET_EDGES) ? tms_run_reg :
				tms_run_reg + 3'h1;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ir_shift_reg <= IR_RESET_VAL;
		else if (tck_rise)
		begin
			if (state_reg == ST_CAP_IR)
				ir_shift_reg <= {IR_CAPTURE_TOP[2], IR_CAPTURE_PAT};
			else if (state_reg == ST_SHIFT_IR)
				ir_shift_reg <= {tdi_s, ir_shift_reg[IR_W-1:1]};
		end
	end

	// active instruction
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ir_reg <= IR_RESET_VAL;
		else if (tck_rise)
		begin
			if (state_next == ST_RESET)
				ir_reg <= IR_RESET_VAL;
			else if (state_reg == ST_UPD_IR)
				ir_reg <= ir_shift_reg;
		end
	end

	// bypass cell; private codes land here too
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			bypass_reg <= 1'b0;
		else if (tck_rise)
		begin
			if (state_reg == ST_CAP_DR)
				bypass_reg <= 1'b0;
			else if (state_reg == ST_SHIFT_DR)
				bypass_reg <= tdi_s;
		end
	end

	// identification shifter
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			id_shift_reg <= ID_ROM_VAL;
		else if (tck_rise && ir_reg == INS_IDCODE)
		begin
			if (state_reg == ST_CAP_DR)
				id_shift_reg <= ID_ROM_VAL;
			else if (state_reg == ST_SHIFT_DR)
				id_shift_reg <= {tdi_s, id_shift_reg[ID_W-1:1]};
		end
	end

	// boundary shifter; no internal test code exists
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			bsr_shift_reg <= '0;
		else if (tck_rise && is_boundary(ir_reg))
		begin
			if (state_reg == ST_CAP_DR)
				bsr_shift_reg <= {BSR_FILL_VAL, out_s, in_s};
			else if (state_reg == ST_SHIFT_DR)
				bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_W-1:1]};
		end
	end

	// holding latches of output cells
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			hold_reg <= BSR_HOLD_RESET;
		else if (tck_rise && state_reg == ST_UPD_DR && is_boundary(ir_reg))
			hold_reg <= bsr_shift_reg[BSR_OUT_LSB +: BSR_OUT_W];
	end

	// inputs never gated; outputs move on fall
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			bout <= '{drive: 1'b0, hiz: 1'b0, value: BSR_HOLD_RESET};
		else if (tck_fall)
		begin
			bout.drive <= (ir_reg == INS_EXTEST);
			bout.hiz <= (ir_reg == INS_SAMPLE_Z);
			bout.value <= hold_reg;
		end
	end

	// data out changes on the falling edge only
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			tdo_o <= 1'b0;
			tdo_oe <= 1'b0;
		end
		else if (tck_fall)
		begin
			tdo_oe <= (state_reg == ST_SHIFT_IR) || (state_reg == ST_SHIFT_DR);
			if (state_reg == ST_SHIFT_IR)
				tdo_o <= ir_shift_reg[0];
			else
				tdo_o <= dr_lsb(ir_reg, bypass_reg, id_shift_reg[0],
					bsr_shift_reg[0]);
		end
	end

	// checks on the decoder behaviour
	sequence s_rise_in(tapid_state_e st);
		tck_rise && state_reg == st;
	endsequence
	property p_cap_ir;
		@(posedge core_clk) disable iff (rst)
		s_rise_in(ST_CAP_IR) |=> ir_shift_reg[1:0] == IR_CAPTURE_PAT;
	endproperty
	a_cap_ir: assert property (p_cap_ir)
		else $error("capture-ir pattern wrong");
	property p_ir_steady;
		@(posedge core_clk) disable iff (rst)
		!(tck_rise && (state_reg == ST_UPD_IR || state_next == ST_RESET))
		|=> $stable(ir_reg);
	endproperty
	a_ir_steady: assert property (p_ir_steady)
		else $error("instruction changed outside update");
	property p_ir_reset;
		@(posedge core_clk) disable iff (rst)
		tck_rise && state_next == ST_RESET |=> ir_reg == INS_IDCODE;
	endproperty
	a_ir_reset: assert property (p_ir_reset)
		else $error("instruction not idcode after reset state");
	property p_bypass;
		@(posedge core_clk) disable iff (rst)
		s_rise_in(ST_SHIFT_DR) ##0 ir_reg == INS_BYPASS
		|=> bypass_reg == $past(tdi_s);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass cell did not take data in");
	property p_id_load;
		@(posedge core_clk) disable iff (rst)
		s_rise_in(ST_CAP_DR) ##0 ir_reg == INS_IDCODE
		|=> id_shift_reg == ID_ROM_VAL;
	endproperty
	a_id_load: assert property (p_id_load)
		else $error("id rom not loaded");
	property p_bsr_fill;
		@(posedge core_clk) disable iff (rst)
		s_rise_in(ST_CAP_DR) ##0 is_boundary(ir_reg)
		|=> bsr_shift_reg[BSR_FILL_LSB +: BSR_FILL_W] == BSR_FILL_VAL;
	endproperty
	a_bsr_fill: assert property (p_bsr_fill)
		else $error("place holder cells not at default");
	property p_tms_reset;
		@(posedge core_clk) disable iff (rst)
		tms_run_reg == TMS_RESET_EDGES |-> state_reg == ST_RESET;
	endproperty
	a_tms_reset: assert property (p_tms_reset)
		else $error("five select-high edges missed reset");
	// data out enable follows shift states
	property p_tdo_oe;
		@(posedge core_clk) disable iff (rst)
		tck_fall |=> tdo_oe == ((state_reg == ST_SHIFT_IR)
			|| (state_reg == ST_SHIFT_DR));
	endproperty
	a_tdo_oe: assert property (p_tdo_oe)
		else $error("data out enable outside shift states");
	// extest drives after a falling edge
	property p_extest_drive;
		@(posedge core_clk) disable iff (rst)
		tck_fall && ir_reg == INS_EXTEST |=> bout.drive
			&& bout.value == $past(hold_reg);
	endproperty
	a_extest_drive: assert property (p_extest_drive)
		else $error("extest did not drive held values");
	property p_hiz;
		@(posedge core_clk) disable iff (rst)
		tck_fall && ir_reg == INS_SAMPLE_Z |=> bout.hiz && !bout.drive;
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("outputs not forced high impedance");

endmodule // tapid_top
`default_nettype wire

// [tapid_scan_ctrl.sv]
// Purpose: scan controller model on the far side of the test link
// Assumes: called at a core_clk fall; one bit spans 8 core cycles
// Notes: tdo is taken just before the next tck fall, where it is settled
`timescale 1ns/100ps
`default_nettype none
module tapid_scan_ctrl
	import tapid_pkg::*;
(
	// clock
	input wire logic core_clk,
	// test link
	output tapid_link_s link,
	input wire logic tdo_o,
	input wire logic tdo_oe
);
	// idle link: clock low, select and data high
	initial
	begin
		link = 3'h3;
	end

	// pins change at fall, held over rise
	task automatic clock_bit(input logic m, input logic d,
		output logic t, output logic e);
	begin
		link = {1'b0, m, d};
		repeat (4) @(negedge core_clk);
		link.tck = 1'b1;
		repeat (4) @(negedge core_clk);
		t = tdo_o;
		e = tdo_oe;
	end
	endtask
endmodule // tapid_scan_ctrl
`default_nettype wire

// [tapid_top_bench.sv]
// Purpose: self-checking bench of the test port decoder
// Assumes: scan controller model drives the link at 32 ns per bit
// Notes: reference tracks state, instruction and data path per bit
`timescale 1ns/100ps
`default_nettype none
module tapid_top_bench
	import tapid_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	tapid_link_s link;
	logic tdo_o;
	logic tdo_oe;
	logic [3:0] ring_in_lvl = 4'h0;
	logic [3:0] ring_out_lvl = 4'h0;
	tapid_bout_s bout;
	int failures = 0;
	int compares = 0;
	int seed = 32'h9c79;
	tapid_state_e st;
	logic [2:0] ir;
	logic [2:0] irsh;
	logic [31:0] dr;
	logic [3:0] hold;
	logic [2:0] codes [5] = '{INS_SAMPLE, INS_EXTEST, INS_SAMPLE_Z,
		INS_BYPASS, INS_IDCODE};

	// core clock, 4 ns
	initial
	begin
		forever #2 core_clk = ~core_clk;
	end

	tapid_top dut (.core_clk(core_clk), .rst(rst), .link_in(link),
		.tdo_o(tdo_o), .tdo_oe(tdo_oe), .ring_in_lvl(ring_in_lvl),
		.ring_out_lvl(ring_out_lvl), .bout(bout));

	tapid_scan_ctrl ctrl (.core_clk(core_clk), .link(link),
		.tdo_o(tdo_o), .tdo_oe(tdo_oe));

	// reference next state
	function automatic tapid_state_e nxt(input tapid_state_e s,
		input logic m);
	begin
		case (s)
			ST_RESET: nxt = m ? ST_RESET : ST_IDLE;
			ST_IDLE: nxt = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: nxt = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR, ST_SHIFT_DR: nxt = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: nxt = m ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: nxt = m ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: nxt = m ? ST_UPD_DR : ST_SHIFT_DR;
			ST_SEL_IR: nxt = m ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR, ST_SHIFT_IR: nxt = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: nxt = m ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: nxt = m ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: nxt = m ? ST_UPD_IR : ST_SHIFT_IR;
			default: nxt = m ? ST_SEL_DR : ST_IDLE;
		endcase
	end
	endfunction

	// codes that route the boundary chain
	function automatic logic bnd(input logic [2:0] c);
		return c == INS_EXTEST || c == INS_SAMPLE_Z || c == INS_SAMPLE;
	endfunction

	// compare and count
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] x);
	begin
		compares++;
		if (s !== x)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	end
	endtask

	// verdict and end of run
	task automatic close_out();
	begin
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask

	// one tck bit: drive, compare what the fall showed, advance model
	task automatic step(input logic m, input logic d);
		logic t;
		logic e;
		logic sh;
		logic [3:0] ri;
		logic [3:0] ro;
		int n;
	begin
		ri = 4'($random(seed));
		ro = 4'($random(seed));
		// ring levels steady across the rise
		ring_in_lvl = ri;
		ring_out_lvl = ro;
		sh = (st == ST_SHIFT_IR) || (st == ST_SHIFT_DR);
		ctrl.clock_bit(m, d, t, e);
		chk("tdo_oe", 32'(e), 32'(sh));
		if (sh)
			chk("tdo", 32'(t), 32'(st == ST_SHIFT_IR ? irsh[0] : dr[0]));
		chk("bout", 32'(bout), {26'h0, ir == INS_EXTEST,
			ir == INS_SAMPLE_Z, hold});
		n = bnd(ir) ? BSR_W : (ir == INS_IDCODE ? ID_W : 1);
		case (st)
			ST_CAP_IR: irsh = {1'b0, IR_CAPTURE_PAT};
			ST_SHIFT_IR: irsh = {d, irsh[2:1]};
			ST_UPD_IR: ir = irsh;
			ST_CAP_DR: dr = bnd(ir) ? 32'({BSR_FILL_VAL, ro, ri}) :
				(ir == INS_IDCODE ? ID_ROM_VAL : 32'h0);
			ST_SHIFT_DR:
			begin
				dr = dr >> 1;
				dr[n-1] = d;
			end
			ST_UPD_DR: if (bnd(ir)) hold = dr[BSR_OUT_LSB +: BSR_OUT_W];
			default: ;
		endcase
		st = nxt(st, m);
		if (st == ST_RESET) ir = INS_IDCODE;
	end
	endtask

	// select sequence, first bit in bit 0, random data
	task automatic walk(input logic [7:0] m, input int n);
	begin
		for (int k = 0; k < n; k++)
			step(m[k], 1'($random(seed)));
	end
	endtask

	task automatic scan_ir(input logic [2:0] c);
	begin
		walk(8'h03, 4);
		for (int k = 0; k < IR_W; k++)
			step(k == IR_W - 1, c[k]);
		walk(8'h01, 2);
	end
	endtask

	// data scan from idle, leaving through pause
	task automatic scan_dr(input int n);
	begin
		walk(8'h01, 3);
		for (int k = 0; k < n; k++)
			step(k == n - 1, 1'($random(seed)));
		walk(8'h06, 4);
	end
	endtask

	// main sequence
	initial
	begin
		st = ST_RESET;
		ir = INS_IDCODE;
		irsh = 3'h1;
		dr = 32'h0;
		hold = BSR_HOLD_RESET;
		repeat (12) @(posedge core_clk);
		chk("reset", 32'({tdo_o, tdo_oe, bout}), 32'h0);
		@(negedge core_clk);
		rst = 1'b0;
		repeat (3) @(negedge core_clk);
		walk(8'h00, 1);
		scan_dr(ID_W);
		for (int r = 0; r < 2; r++)
			foreach (codes[i])
			begin
				scan_ir(codes[i]);
				scan_dr(ID_W + 2);
			end
		scan_ir(INS_EXTEST);
		walk(8'h01, 5);
		walk(8'h1f, 5);
		walk(8'h00, 1);
		scan_dr(ID_W);
		close_out();
	end

	// hang guard
	initial
	begin
		repeat (40000) @(posedge core_clk);
		failures++;
		close_out();
	end
endmodule // tapid_top_bench
`default_nettype wire
